// ---- shared/abu_pkg.sv ----
// Purpose: constants for the address breakpoint unit
// Assumes: 8-bit register port, 16-bit cpu address
// Notes: register offsets are local indices on the plain register port
package abu_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CPU_AW = 16;
	// register indices
	localparam logic [2:0] REG_STATUS_CONTROL = 3'h0;
	localparam logic [2:0] REG_ADDR_HIGH = 3'h1;
	localparam logic [2:0] REG_ADDR_LOW = 3'h2;
	localparam logic [2:0] REG_WAIT_EXIT = 3'h3;
	localparam logic [2:0] REG_FLAG_CLEAR = 3'h4;
	localparam logic [2:0] REG_IRQ_STATUS = 3'h5;
	localparam logic [2:0] REG_IRQ_MASK = 3'h6;
	// field positions
	localparam int BIT_ENABLE = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_WAIT_EXIT = 1;
	localparam int BIT_FLAG_CLEAR = 0;
	// interrupt status bits
	localparam int EV_MATCH = 0;
	localparam int EV_SOFT = 1;
	localparam int EV_ENTER = 2;
	localparam int EV_EXIT = 3;
	localparam int EV_N = 4;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ADDR = 16'h0000;
	// break vectors
	localparam logic [15:0] VEC_USER = 16'hFFFC;
	localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_PEND = 2'b01,
		ST_BREAK = 2'b10
	} abu_state_e;
endpackage : abu_pkg

// ---- src/abu_top.sv ----
// Purpose: address breakpoint unit with break-state side controls
// Assumes: cpu signals are synchronous to mclk_i; vdetect pin is asynchronous
// Assumes: the cpu raises acknowledge only while the request stands
// Notes: request is held until the cpu acknowledges it at an instruction boundary
// Notes: a zero write to the active bit loses to a same-cycle match
//
// How it works
// - enabled break plus address equal to break address raises breakpoint request
// - break forces software interrupt opcode, vector FFFC user or FEFC monitor
// - opcode match: request taken before that instruction executes
// - operand match: request held until current instruction ends, then taken
// - writing one to active bit forces break before next instruction
// - active bit set by match, cleared by writing zero or reset
// - enable bit is bit 7, full 16-bit compare, cleared by zero or reset
// - break address high and low bytes readable, writable, reset to zero
// - while active bit stays clear after break, same address gives no new break
// - return-from-interrupt in break routine ends break state
// - flag clears in break state allowed only when flag-clear enable set
// - timer counter halted while break is active
// - watchdog disabled in break when high test voltage on reset pin
// - wait-exit flag reads one when wait mode left by a break
// - no match breaks in wait or stop since address bus is frozen
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module abu_top
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [abu_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [abu_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [abu_pkg::DATA_W-1:0] reg_rdata_o,
	// cpu side
	input wire logic [abu_pkg::CPU_AW-1:0] cpu_addr_i,
	input wire logic cpu_addr_valid_i,
	input wire logic cpu_opcode_fetch_i,
	input wire logic cpu_instr_boundary_i,
	input wire logic cpu_break_ack_i,
	input wire logic cpu_rti_i,
	input wire logic cpu_wait_i,
	input wire logic cpu_stop_i,
	input wire logic monitor_mode_i,
	// status clear protection
	input wire logic flag_clear_req_i,
	// pins
	input wire logic high_test_voltage_i,
	// outputs to system integration logic
	output logic breakpoint_request_o,
	output logic force_swi_o,
	output logic [abu_pkg::CPU_AW-1:0] break_vector_o,
	output logic break_state_o,
	output logic flag_clear_allow_o,
	output logic timer_halt_o,
	output logic watchdog_disable_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	logic break_enable_bit_r;
	logic break_active_bit_r;
	logic [abu_pkg::CPU_AW-1:0] brk_addr_r;
	logic flag_clear_in_break_enable_r;
	logic wait_exit_by_break_flag_r;
	logic [abu_pkg::EV_N-1:0] irq_status_r;
	logic [abu_pkg::EV_N-1:0] irq_mask_r;
	logic [abu_pkg::EV_N-1:0] irq_event;
	abu_pkg::abu_state_e state_r;
	logic last_hit_r;
	logic [abu_pkg::CPU_AW-1:0] last_addr_r;
	logic vdet_meta_r;
	logic vdet_sync_r;
	logic addr_match;
	logic soft_break;
	logic active_wr_zero;
	logic enter_break;
	logic exit_break;
	logic addr_equal;
	logic bus_frozen;
	logic rearm_block;
	logic wr_status_ctl;
	logic wr_addr_byte;
	logic break_live;
	logic [abu_pkg::DATA_W-1:0] rdata_nxt;

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser; the test voltage moves slowly, so two flops suffice
	// and nothing but the second flop is read by the logic
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			vdet_meta_r <= 1'b0;
			vdet_sync_r <= 1'b0;
		end
		else
		begin
			vdet_meta_r <= high_test_voltage_i;
			vdet_sync_r <= vdet_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// match: frozen bus in low-power modes never matches; a cleared active bit
	// with an unchanged address keeps the last hit from breaking again
	assign addr_equal = cpu_addr_valid_i && (cpu_addr_i == brk_addr_r);
	assign bus_frozen = cpu_wait_i || cpu_stop_i;
	assign rearm_block = !break_active_bit_r && last_hit_r
		&& (cpu_addr_i == last_addr_r);
	assign addr_match = break_enable_bit_r && addr_equal && !bus_frozen
		&& (state_r == abu_pkg::ST_RUN) && !rearm_block;

	assign wr_status_ctl = reg_wr_i && (reg_addr_i == abu_pkg::REG_STATUS_CONTROL);
	assign wr_addr_byte = reg_wr_i && (reg_addr_i == abu_pkg::REG_ADDR_HIGH
		|| reg_addr_i == abu_pkg::REG_ADDR_LOW);
	assign soft_break = wr_status_ctl && reg_wdata_i[abu_pkg::BIT_ACTIVE];
	assign active_wr_zero = wr_status_ctl && !reg_wdata_i[abu_pkg::BIT_ACTIVE];
	assign enter_break = (state_r == abu_pkg::ST_PEND) && cpu_break_ack_i;
	assign exit_break = (state_r == abu_pkg::ST_BREAK) && cpu_rti_i;
	// one cycle ahead of the registered side outputs so they line up with state
	assign break_live = ((state_r == abu_pkg::ST_BREAK) && !exit_break) || enter_break;

	////////////////////////////////////////////////////////////////////////////
	// last-hit memory for the re-arm behaviour; a new address write wins over
	// a hit in the same cycle so software re-arming is never lost
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			last_hit_r <= 1'b0;
		else if (wr_addr_byte)
			last_hit_r <= 1'b0; // new address re-arms
		else if (addr_match)
			last_hit_r <= 1'b1;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			last_addr_r <= abu_pkg::RST_ADDR;
		else if (addr_match && !wr_addr_byte)
			last_addr_r <= cpu_addr_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// state machine; pend spans the gap between request and cpu acknowledge,
	// so a second cause arriving meanwhile cannot queue another break
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			state_r <= abu_pkg::ST_RUN;
		else
		begin
			case (state_r)
				abu_pkg::ST_RUN:
					if (addr_match || soft_break)
						state_r <= abu_pkg::ST_PEND;
				abu_pkg::ST_PEND:
					if (enter_break)
						state_r <= abu_pkg::ST_BREAK;
				abu_pkg::ST_BREAK:
					if (exit_break)
						state_r <= abu_pkg::ST_RUN;
				default:
					state_r <= abu_pkg::ST_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request: opcode match goes out at once, operand match waits for the
	// instruction boundary so the instruction completes first
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			breakpoint_request_o <= 1'b0;
		else if (enter_break)
			breakpoint_request_o <= 1'b0;
		else if (addr_match && cpu_opcode_fetch_i)
			breakpoint_request_o <= 1'b1;
		else if (soft_break && state_r == abu_pkg::ST_RUN)
			breakpoint_request_o <= 1'b1;
		else if (state_r == abu_pkg::ST_PEND && cpu_instr_boundary_i)
			breakpoint_request_o <= 1'b1;
	end

	// swi force is a one-cycle pulse on the edge after the acknowledge
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			force_swi_o <= 1'b0;
		else
			force_swi_o <= enter_break;
	end

	// vector follows the mode level every cycle, settled well before the swi fetch
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			break_vector_o <= abu_pkg::VEC_USER;
		else
			break_vector_o <= monitor_mode_i ? abu_pkg::VEC_MONITOR
				: abu_pkg::VEC_USER;
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers, one per concern
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			break_enable_bit_r <= 1'b0;
		else if (wr_status_ctl)
			break_enable_bit_r <= reg_wdata_i[abu_pkg::BIT_ENABLE];
	end

	// the two address bytes load separately, with no latching between them
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			brk_addr_r <= abu_pkg::RST_ADDR;
		else if (reg_wr_i && reg_addr_i == abu_pkg::REG_ADDR_HIGH)
			brk_addr_r[15:8] <= reg_wdata_i;
		else if (reg_wr_i && reg_addr_i == abu_pkg::REG_ADDR_LOW)
			brk_addr_r[7:0] <= reg_wdata_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			flag_clear_in_break_enable_r <= 1'b0;
		else if (reg_wr_i && reg_addr_i == abu_pkg::REG_FLAG_CLEAR)
			flag_clear_in_break_enable_r <= reg_wdata_i[abu_pkg::BIT_FLAG_CLEAR];
	end

	// active bit: hardware set wins over the zero write
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			break_active_bit_r <= 1'b0;
		else if (addr_match || soft_break)
			break_active_bit_r <= 1'b1;
		else if (active_wr_zero)
			break_active_bit_r <= 1'b0;
	end

	// wait-exit flag: set when the break arrives while waiting; cleared on
	// return so a later break taken outside wait never reports a stale exit
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			wait_exit_by_break_flag_r <= 1'b0;
		else if (enter_break && cpu_wait_i)
			wait_exit_by_break_flag_r <= 1'b1;
		else if (reg_wr_i && reg_addr_i == abu_pkg::REG_WAIT_EXIT
			&& !reg_wdata_i[abu_pkg::BIT_WAIT_EXIT])
			wait_exit_by_break_flag_r <= 1'b0;
		else if (exit_break)
			wait_exit_by_break_flag_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// break-state side effects, one register per output
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			break_state_o <= 1'b0;
		else
			break_state_o <= break_live;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			timer_halt_o <= 1'b0;
		else
			timer_halt_o <= break_live;
	end

	// only the synced pin is read, so a slow voltage edge cannot glitch the gate
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			watchdog_disable_o <= 1'b0;
		else
			watchdog_disable_o <= break_live && vdet_sync_r;
	end

	// outside break every clear passes; inside, only with the enable bit set
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			flag_clear_allow_o <= 1'b0;
		else
			flag_clear_allow_o <= flag_clear_req_i
				&& (state_r != abu_pkg::ST_BREAK || flag_clear_in_break_enable_r);
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, set wins
	assign irq_event[abu_pkg::EV_MATCH] = addr_match;
	assign irq_event[abu_pkg::EV_SOFT] = soft_break;
	assign irq_event[abu_pkg::EV_ENTER] = enter_break;
	assign irq_event[abu_pkg::EV_EXIT] = exit_break;

	// one flop per event, so a clear of one bit never races a set of another
	genvar gi;
	generate
		for (gi = 0; gi < abu_pkg::EV_N; gi++)
		begin : g_irq
			always_ff @(posedge mclk_i or posedge rst_i)
			begin
				if (rst_i)
					irq_status_r[gi] <= 1'b0;
				else if (irq_event[gi])
					irq_status_r[gi] <= 1'b1;
				else if (reg_wr_i && reg_addr_i == abu_pkg::REG_IRQ_STATUS
					&& reg_wdata_i[gi])
					irq_status_r[gi] <= 1'b0;
			end
		end
	endgenerate

	// a one in the mask lets the matching status bit drive the interrupt
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_mask_r <= '0;
		else if (reg_wr_i && reg_addr_i == abu_pkg::REG_IRQ_MASK)
			irq_mask_r <= reg_wdata_i[abu_pkg::EV_N-1:0];
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status_r & irq_mask_r);
	end

	////////////////////////////////////////////////////////////////////////////
	// read decode; unmapped indices read zero and reads have no side effects,
	// so polling a status register never loses an event
	always_comb
	begin
		rdata_nxt = abu_pkg::RST_BYTE;
		if (reg_addr_i == abu_pkg::REG_STATUS_CONTROL)
			rdata_nxt = {break_enable_bit_r, break_active_bit_r, 6'h00};
		else if (reg_addr_i == abu_pkg::REG_ADDR_HIGH)
			rdata_nxt = brk_addr_r[15:8];
		else if (reg_addr_i == abu_pkg::REG_ADDR_LOW)
			rdata_nxt = brk_addr_r[7:0];
		else if (reg_addr_i == abu_pkg::REG_WAIT_EXIT)
			rdata_nxt = {6'h00, wait_exit_by_break_flag_r, 1'b0};
		else if (reg_addr_i == abu_pkg::REG_FLAG_CLEAR)
			rdata_nxt = {7'h00, flag_clear_in_break_enable_r};
		else if (reg_addr_i == abu_pkg::REG_IRQ_STATUS)
			rdata_nxt = {4'h0, irq_status_r};
		else if (reg_addr_i == abu_pkg::REG_IRQ_MASK)
			rdata_nxt = {4'h0, irq_mask_r};
	end

	// read port, data one cycle after the strobe and zero otherwise
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= abu_pkg::RST_BYTE;
		else if (reg_rd_i)
			reg_rdata_o <= rdata_nxt;
		else
			reg_rdata_o <= abu_pkg::RST_BYTE;
	end

endmodule : abu_top

// ---- sim/abu_top_monitor.sv ----
// Purpose: port-level checks of the address breakpoint unit
// Assumes: one clock domain, async high reset
// Notes: flag-clear enable is mirrored from register writes
`timescale 1ns/1ps
module abu_top_monitor
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// observed inputs
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic cpu_addr_valid_i,
	input wire logic cpu_instr_boundary_i,
	input wire logic cpu_break_ack_i,
	input wire logic cpu_rti_i,
	input wire logic monitor_mode_i,
	input wire logic flag_clear_req_i,
	input wire logic high_test_voltage_i,
	// observed outputs
	input wire logic breakpoint_request_o,
	input wire logic force_swi_o,
	input wire logic [15:0] break_vector_o,
	input wire logic break_state_o,
	input wire logic flag_clear_allow_o,
	input wire logic timer_halt_o,
	input wire logic watchdog_disable_o
);
	logic fce_r;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			fce_r <= 1'b0;
		else if (reg_wr_i && reg_addr_i == abu_pkg::REG_FLAG_CLEAR)
			fce_r <= reg_wdata_i[abu_pkg::BIT_FLAG_CLEAR];
	end
	////////////////////////////////////////////////////////////////////////////////
	a_req_cause: assert property ($rose(breakpoint_request_o) |->
		$past(cpu_addr_valid_i) || $past(reg_wr_i) || $past(cpu_instr_boundary_i))
		else $error("request without cause");
	a_req_hold: assert property (breakpoint_request_o && !cpu_break_ack_i |=>
		breakpoint_request_o) else $error("request dropped before ack");
	a_ack_swi: assert property (breakpoint_request_o && cpu_break_ack_i |=>
		force_swi_o && break_state_o && !breakpoint_request_o) else $error("ack not taken");
	a_swi_pulse: assert property (force_swi_o |=> !force_swi_o)
		else $error("swi force too long");
	a_vec_mon: assert property (monitor_mode_i ##1 monitor_mode_i |->
		break_vector_o == abu_pkg::VEC_MONITOR) else $error("monitor vector wrong");
	a_halt_follows: assert property (timer_halt_o == break_state_o)
		else $error("timer halt differs from break state");
	a_rti_ends: assert property (break_state_o && cpu_rti_i |=> !break_state_o)
		else $error("break state kept after rti");
	a_wdog_on: assert property ((break_state_o && high_test_voltage_i) [*4] |->
		watchdog_disable_o) else $error("watchdog not disabled");
	a_wdog_off: assert property (!high_test_voltage_i [*4] |-> !watchdog_disable_o)
		else $error("watchdog disabled without voltage");
	a_flag_block: assert property (break_state_o && !fce_r && flag_clear_req_i |=>
		!flag_clear_allow_o) else $error("flag clear allowed in break");
	c_soft: cover property (reg_wr_i ##1 breakpoint_request_o);
	c_enter: cover property ($rose(break_state_o));
	c_wdog: cover property (watchdog_disable_o);
endmodule : abu_top_monitor

bind abu_top abu_top_monitor i_abu_top_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.cpu_addr_valid_i(cpu_addr_valid_i), .cpu_instr_boundary_i(cpu_instr_boundary_i),
	.cpu_break_ack_i(cpu_break_ack_i), .cpu_rti_i(cpu_rti_i), .monitor_mode_i(monitor_mode_i),
	.flag_clear_req_i(flag_clear_req_i), .high_test_voltage_i(high_test_voltage_i),
	.breakpoint_request_o(breakpoint_request_o), .force_swi_o(force_swi_o),
	.break_vector_o(break_vector_o), .break_state_o(break_state_o),
	.flag_clear_allow_o(flag_clear_allow_o), .timer_halt_o(timer_halt_o),
	.watchdog_disable_o(watchdog_disable_o));

// ---- sim/abu_cpu_model.sv ----
// Purpose: cpu core stand-in facing the breakpoint unit
// Assumes: bench calls the tasks one at a time
// Notes: ack_dly sets how slowly a request is taken
`timescale 1ns/1ps
module abu_cpu_model
(
	input wire logic mclk_i,
	input wire logic breakpoint_request_i,
	output logic [15:0] cpu_addr_o,
	output logic cpu_addr_valid_o,
	output logic cpu_opcode_fetch_o,
	output logic cpu_instr_boundary_o,
	output logic cpu_break_ack_o,
	output logic cpu_rti_o
);
	int ack_dly = 2;
	int wait_n = 0;
	initial
	begin
		cpu_addr_o = 16'h0000;
		cpu_addr_valid_o = 1'b0;
		cpu_opcode_fetch_o = 1'b0;
		cpu_instr_boundary_o = 1'b0;
		cpu_break_ack_o = 1'b0;
		cpu_rti_o = 1'b0;
	end
	// released address shows the inverse, never a stale copy
	task automatic bus(input logic [15:0] a, input logic op);
		@(posedge mclk_i);
		cpu_addr_o <= a;
		cpu_addr_valid_o <= 1'b1;
		cpu_opcode_fetch_o <= op;
		@(posedge mclk_i);
		cpu_addr_o <= ~a;
		cpu_addr_valid_o <= 1'b0;
		cpu_opcode_fetch_o <= 1'b0;
	endtask : bus
	task automatic boundary();
		@(posedge mclk_i);
		cpu_instr_boundary_o <= 1'b1;
		@(posedge mclk_i);
		cpu_instr_boundary_o <= 1'b0;
	endtask : boundary
	task automatic return_from_interrupt_instruction();
		@(posedge mclk_i);
		cpu_rti_o <= 1'b1;
		@(posedge mclk_i);
		cpu_rti_o <= 1'b0;
	endtask : return_from_interrupt_instruction
	always @(posedge mclk_i)
	begin
		cpu_break_ack_o <= 1'b0;
		if (!breakpoint_request_i || cpu_break_ack_o)
			wait_n <= 0;
		else if (wait_n >= ack_dly)
			cpu_break_ack_o <= 1'b1;
		else
			wait_n <= wait_n + 1;
	end
endmodule : abu_cpu_model

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench of the address breakpoint unit
// Assumes: cpu model answers requests on its own
// Notes: a one in the irq mask passes its status bit to the interrupt line
`timescale 1ns/1ps
module tb_top;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_wait = 1'b0, cpu_stop = 1'b0;
	logic monitor = 1'b0, fcr = 1'b0, htv = 1'b0;
	logic [7:0] rdata;
	logic [15:0] vec, ca;
	logic req, software_interrupt_instruction, bst, fca, thalt, wdd, irq, cav, cof, cib, cba, crti;
	int error_cnt = 0, n_compared = 0;
	abu_top i_abu_top (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.cpu_addr_i(ca), .cpu_addr_valid_i(cav), .cpu_opcode_fetch_i(cof),
		.cpu_instr_boundary_i(cib), .cpu_break_ack_i(cba), .cpu_rti_i(crti),
		.cpu_wait_i(cpu_wait), .cpu_stop_i(cpu_stop), .monitor_mode_i(monitor),
		.flag_clear_req_i(fcr), .high_test_voltage_i(htv), .breakpoint_request_o(req),
		.force_swi_o(software_interrupt_instruction), .break_vector_o(vec), .break_state_o(bst),
		.flag_clear_allow_o(fca), .timer_halt_o(thalt), .watchdog_disable_o(wdd), .irq_o(irq));
	abu_cpu_model i_abu_cpu_model (.mclk_i(mclk_i), .breakpoint_request_i(req),
		.cpu_addr_o(ca), .cpu_addr_valid_o(cav), .cpu_opcode_fetch_o(cof),
		.cpu_instr_boundary_o(cib), .cpu_break_ack_o(cba), .cpu_rti_o(crti));
	initial forever #4 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk_i);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk_i);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic wait_brk(input logic mon);
		int n;
		n = 0;
		while (bst !== 1'b1 && n < 40)
		begin
			@(posedge mclk_i);
			#1 n++;
		end
		chk("break_state", bst, 1'b1);
		chk("timer_halt", thalt, 1'b1);
		chk("vector", vec, mon ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_USER);
	endtask : wait_brk
	task automatic end_brk();
		i_abu_cpu_model.return_from_interrupt_instruction();
		#1 chk("break_end", bst, 1'b0);
	endtask : end_brk
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] d;
		for (int i = 0; i < 8; i++)
		begin
			rd(3'(i), d);
			chk("reset_value", d, 8'h00);
		end
		wr(abu_pkg::REG_ADDR_HIGH, 8'h12);
		wr(abu_pkg::REG_ADDR_LOW, 8'h34);
		wr(3'h7, 8'hFF);
		rd(abu_pkg::REG_ADDR_HIGH, d);
		chk("addr_high", d, 8'h12);
		rd(abu_pkg::REG_ADDR_LOW, d);
		chk("addr_low", d, 8'h34);
		rd(3'h7, d);
		chk("unmapped", d, 8'h00);
	endtask : t_regs
	task automatic t_match();
		logic [7:0] d;
		wr(abu_pkg::REG_STATUS_CONTROL, 8'h80);
		i_abu_cpu_model.bus(16'h1235, 1'b1);
		#1 chk("near_miss", req, 1'b0);
		i_abu_cpu_model.bus(16'h1234, 1'b1);
		#1 chk("request", req, 1'b1);
		rd(abu_pkg::REG_STATUS_CONTROL, d);
		chk("active_set", d, 8'hC0);
		wait_brk(1'b0);
		end_brk();
		wr(abu_pkg::REG_STATUS_CONTROL, 8'h80);
		rd(abu_pkg::REG_STATUS_CONTROL, d);
		chk("active_clear", d, 8'h80);
		i_abu_cpu_model.bus(16'h1234, 1'b1);
		#1 chk("no_rebreak", req, 1'b0);
	endtask : t_match
	task automatic t_operand();
		i_abu_cpu_model.ack_dly = 0;
		monitor <= 1'b1;
		wr(abu_pkg::REG_ADDR_LOW, 8'h40);
		i_abu_cpu_model.bus(16'h1240, 1'b0);
		#1 chk("operand_wait", req, 1'b0);
		i_abu_cpu_model.boundary();
		#1 chk("operand_req", req, 1'b1);
		wait_brk(1'b1);
		end_brk();
		monitor <= 1'b0;
		i_abu_cpu_model.ack_dly = 6;
	endtask : t_operand
	task automatic t_wait_soft();
		logic [7:0] d;
		wr(abu_pkg::REG_ADDR_LOW, 8'h50);
		wr(abu_pkg::REG_STATUS_CONTROL, 8'h80);
		cpu_stop <= 1'b1;
		i_abu_cpu_model.bus(16'h1250, 1'b1);
		#1 chk("stop_no_break", req, 1'b0);
		cpu_stop <= 1'b0;
		cpu_wait <= 1'b1;
		i_abu_cpu_model.bus(16'h1250, 1'b1);
		#1 chk("wait_no_break", req, 1'b0);
		wr(abu_pkg::REG_STATUS_CONTROL, 8'hC0);
		#1 chk("soft_req", req, 1'b1);
		fcr <= 1'b1;
		htv <= 1'b1;
		wait_brk(1'b0);
		cpu_wait <= 1'b0;
		rd(abu_pkg::REG_WAIT_EXIT, d);
		chk("wait_exit", d, 8'h02);
		chk("flag_blocked", fca, 1'b0);
		repeat (4) @(posedge mclk_i);
		#1 chk("wdog_off", wdd, 1'b1);
		wr(abu_pkg::REG_FLAG_CLEAR, 8'h01);
		@(posedge mclk_i);
		#1 chk("flag_allowed", fca, 1'b1);
		end_brk();
		htv <= 1'b0;
		rd(abu_pkg::REG_WAIT_EXIT, d);
		chk("wait_exit_clr", d, 8'h00);
	endtask : t_wait_soft
	task automatic t_irq();
		logic [7:0] d;
		rd(abu_pkg::REG_IRQ_STATUS, d);
		chk("irq_status", d, 8'h0F);
		wr(abu_pkg::REG_IRQ_MASK, 8'h00);
		repeat (2) @(posedge mclk_i);
		#1 chk("irq_masked", irq, 1'b0);
		wr(abu_pkg::REG_IRQ_MASK, 8'h0F);
		repeat (2) @(posedge mclk_i);
		#1 chk("irq_unmasked", irq, 1'b1);
		wr(abu_pkg::REG_IRQ_STATUS, 8'h0F);
		repeat (2) @(posedge mclk_i);
		#1 chk("irq_cleared", irq, 1'b0);
		rd(abu_pkg::REG_IRQ_STATUS, d);
		chk("irq_status_clr", d, 8'h00);
	endtask : t_irq
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_regs();
		t_match();
		t_operand();
		t_wait_soft();
		t_irq();
		close_out();
	end
	// whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (4000) @(posedge mclk_i);
		error_cnt++;
		close_out();
	end
endmodule : tb_top
